// ### rtl/arc_ctrl.sv
// Reset, reference, channel and calibration control with an Avalon-MM register slave.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module arc_ctrl (
   // Clock and reset.
   input wire logic CLK,
   input wire logic ARST_N,
   // Avalon-MM register slave.
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Serial pins.
   input wire logic SCLK,
   input wire logic DIN,
   input wire logic CS_N,
   output logic DOUT_RDY_N_O,
   output logic DOUT_RDY_N_OE,
   // Modulator side.
   input wire logic [23:0] RAW_IN,
   output logic REF_INTERNAL,
   output logic [1:0] INPUT_SEL,
   output logic [2:0] CHAN_OUT,
   output logic SOFT_RESET
);
   import arc_pkg::*;
   //==============================================================
   // Declarations.
   logic [2:0] sclk_s, din_s, cs_s; // Three-stage pin synchronisers.
   logic sclk_rise; // One-cycle pulse on a qualified SCLK rise.
   logic sclk_lvl_reg; // Accepted SCLK level, moved only when stages two and three agree.
   logic [5:0] ones_reg; // Consecutive ones counter.
   logic soft_rst; // Reset pulse from the ones detector.
   logic ack_reg; // Bus answer phase.
   logic [31:0] rdata_next;
   logic wr_en, rd_en; // Request taken this cycle.
   logic [2:0] mode_reg, chan_reg, gain_reg;
   logic reference_source_select_reg;
   logic [23:0] data_reg;
   logic [23:0] offset_mem [0:7]; // Offset coefficient per channel.
   logic [23:0] fscale_mem [0:7]; // Full-scale coefficient per channel.
   logic rdy_reg; // Ready flag, set by hardware.
   arc_state_t state_reg;
   logic [9:0] div_reg; // Conversion cycle divider.
   logic conv_tick;
   logic [2:0] cal_cnt_reg, cal_len;
   logic [12:0] cal_age_reg; // Cycles spent in the running calibration, read by the checks.
   logic cal_start, cal_done, is_cal;
   logic [24:0] diff;
   logic [47:0] product;
   //==============================================================
   // Decoding.
   // Calibration codes have the top mode bit set.
   function automatic logic is_cal_code(input logic [2:0] m);
      return m[2];
   endfunction : is_cal_code
   // A request is taken in its second cycle, when waitrequest is low.
   assign wr_en = AVS_WRITE & ack_reg;
   assign rd_en = AVS_READ & ack_reg;
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
   assign is_cal = is_cal_code(mode_reg);
   assign cal_start = wr_en && AVS_ADDRESS == OFS_MODE && is_cal_code(AVS_WRITEDATA[POS_MODE +: 3]);
   // Internal full-scale needs four cycles above gain one.
   assign cal_len = (mode_reg == MD_INT_FULL && gain_reg != GAIN_ONE) ? CAL_LONG : CAL_SHORT;
   // A mode write in the finishing cycle restarts the sequencer instead of ending it.
   assign cal_done = state_reg == ST_CAL && conv_tick && cal_cnt_reg == cal_len - 3'h1 &&
                     !(wr_en && AVS_ADDRESS == OFS_MODE);
   // A rise counts once stages two and three both show high over a low accepted level.
   assign sclk_rise = sclk_s[1] & sclk_s[2] & ~sclk_lvl_reg & ~cs_s[2];
   assign soft_rst = sclk_rise && din_s[2] && ones_reg == 6'(RST_ONES - 1);
   // One-cycle enable at the end of every conversion period.
   assign conv_tick = div_reg == 10'(CONV_CLKS - 1);
   // Offset removed before full-scale scaling, clipped at zero.
   assign diff = {1'b0, RAW_IN} - {1'b0, offset_mem[chan_reg]};
   assign product = (diff[24] ? 24'h000000 : diff[23:0]) * fscale_mem[chan_reg];
   // The supply monitor always converts against the internal reference.
   assign REF_INTERNAL = reference_source_select_reg | (chan_reg == CHAN_SUPPLY);
   assign CHAN_OUT = chan_reg;
   assign SOFT_RESET = soft_rst;
   // Internal calibrations swap the input pins for the zero or full-scale source.
   assign INPUT_SEL = (state_reg == ST_CAL && mode_reg == MD_INT_ZERO) ? IN_ZERO :
                      (state_reg == ST_CAL && mode_reg == MD_INT_FULL) ? IN_FULL :
                      (chan_reg == CHAN_SUPPLY) ? IN_SUPPLY : IN_EXT;
   // The pin shows the inverted ready flag only while selected.
   assign DOUT_RDY_N_O = ~rdy_reg;
   assign DOUT_RDY_N_OE = ~cs_s[2];
   // Read data for the addressed register; unmapped places read zero.
   always_comb begin
      rdata_next = 32'h00000000;
      unique case (AVS_ADDRESS)
         OFS_STATUS: rdata_next = {29'h0, state_reg == ST_CAL, 1'b0, ~rdy_reg};
         OFS_MODE: rdata_next = {29'h0, mode_reg};
         OFS_CONFIG: rdata_next = {21'h0, gain_reg, reference_source_select_reg, 4'h0, chan_reg};
         OFS_DATA: rdata_next = {8'h00, data_reg};
         OFS_OFFSET: rdata_next = {8'h00, offset_mem[chan_reg]};
         OFS_FSCALE: rdata_next = {8'h00, fscale_mem[chan_reg]};
         default: rdata_next = 32'h00000000;
      endcase
   end
   //==============================================================
   // Pin synchronisers; first stage feeds only the second.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sclk_s <= 3'h7;
         din_s <= 3'h0;
         cs_s <= 3'h7;
      end else begin
         sclk_s <= {sclk_s[1:0], SCLK};
         din_s <= {din_s[1:0], DIN};
         cs_s <= {cs_s[1:0], CS_N};
      end
   end
   //==============================================================
   // Accepted SCLK level; a change counts once stages two and three agree.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sclk_lvl_reg <= 1'b1;
      end else if (sclk_s[1] == sclk_s[2]) begin
         sclk_lvl_reg <= sclk_s[2];
      end
   end
   //==============================================================
   // Ones detector, counted at selected SCLK rises.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ones_reg <= 6'h00;
      end else if (soft_rst) begin
         ones_reg <= 6'h00;
      end else if (sclk_rise) begin
         ones_reg <= din_s[2] ? ones_reg + 6'h01 : 6'h00;
      end
   end
   //==============================================================
   // Bus handshake: one wait state, read data registered.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_reg <= 1'b0;
         AVS_READDATA <= 32'h00000000;
      end else begin
         ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
         if (AVS_READ && !ack_reg) begin
            AVS_READDATA <= rdata_next;
         end
      end
   end
   //==============================================================
   // Configuration registers; power-up and serial reset restore defaults.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         chan_reg <= RST_CHAN;
         gain_reg <= RST_GAIN;
         reference_source_select_reg <= RST_REFERENCE_SOURCE_SELECT;
      end else if (soft_rst) begin
         chan_reg <= RST_CHAN;
         gain_reg <= RST_GAIN;
         reference_source_select_reg <= RST_REFERENCE_SOURCE_SELECT;
      end else if (wr_en && AVS_ADDRESS == OFS_CONFIG) begin
         chan_reg <= AVS_WRITEDATA[POS_CHAN +: 3];
         gain_reg <= AVS_WRITEDATA[POS_GAIN +: 3];
         reference_source_select_reg <= AVS_WRITEDATA[POS_REFERENCE_SOURCE_SELECT];
      end
   end
   //==============================================================
   // Coefficient memories, written by software or by calibration.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int i = 0; i < 8; i++) begin
            offset_mem[i] <= RST_OFFSET;
            fscale_mem[i] <= RST_FSCALE;
         end
      end else if (soft_rst) begin
         for (int i = 0; i < 8; i++) begin
            offset_mem[i] <= RST_OFFSET;
            fscale_mem[i] <= RST_FSCALE;
         end
      end else if (cal_done) begin
         // Odd calibration codes are the full-scale ones.
         if (mode_reg[0]) begin
            fscale_mem[chan_reg] <= RAW_IN;
         end else begin
            offset_mem[chan_reg] <= RAW_IN;
         end
      end else if (wr_en && AVS_ADDRESS == OFS_OFFSET) begin
         offset_mem[chan_reg] <= AVS_WRITEDATA[23:0];
      end else if (wr_en && AVS_ADDRESS == OFS_FSCALE) begin
         fscale_mem[chan_reg] <= AVS_WRITEDATA[23:0];
      end
   end
   //==============================================================
   // Conversion cycle divider, restarted on each mode write.
   // A running calibration counts its conversion periods from this divider.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         div_reg <= 10'h000;
      end else if (soft_rst || state_reg == ST_IDLE || (wr_en && AVS_ADDRESS == OFS_MODE)) begin
         div_reg <= 10'h000;
      end else begin
         div_reg <= conv_tick ? 10'h000 : div_reg + 10'h001;
      end
   end
   //==============================================================
   // Mode register and sequencer.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mode_reg <= RST_MODE;
         state_reg <= ST_IDLE;
         cal_cnt_reg <= 3'h0;
      end else if (soft_rst) begin
         mode_reg <= RST_MODE;
         state_reg <= ST_IDLE;
         cal_cnt_reg <= 3'h0;
      end else if (wr_en && AVS_ADDRESS == OFS_MODE) begin
         mode_reg <= AVS_WRITEDATA[POS_MODE +: 3];
         cal_cnt_reg <= 3'h0;
         state_reg <= is_cal_code(AVS_WRITEDATA[POS_MODE +: 3]) ? ST_CAL :
                      (AVS_WRITEDATA[1] ? ST_IDLE : ST_CONV);
      end else begin
         // Idle and power-down wait here for the next mode write.
         unique case (state_reg)
            ST_IDLE: state_reg <= ST_IDLE;
            ST_CONV: begin
               if (conv_tick && mode_reg == MD_SINGLE) begin
                  mode_reg <= MD_IDLE;
                  state_reg <= ST_IDLE;
               end
            end
            ST_CAL: begin
               if (cal_done) begin
                  mode_reg <= MD_IDLE;
                  state_reg <= ST_IDLE;
               end else if (conv_tick) begin
                  cal_cnt_reg <= cal_cnt_reg + 3'h1;
               end
            end
         endcase
      end
   end
   //==============================================================
   // Data register and ready flag; a new result wins over a read clear.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         data_reg <= 24'h000000;
         rdy_reg <= 1'b0;
      end else if (soft_rst) begin
         data_reg <= 24'h000000;
         rdy_reg <= 1'b0;
      end else if (cal_done) begin
         rdy_reg <= 1'b1;
      end else if (cal_start) begin
         // A calibration start drops the result of the abandoned conversion.
         rdy_reg <= 1'b0;
      end else if (state_reg == ST_CONV && conv_tick) begin
         data_reg <= product[46:23];
         rdy_reg <= 1'b1;
      end else if (rd_en && AVS_ADDRESS == OFS_DATA) begin
         rdy_reg <= 1'b0;
      end
   end
   //==============================================================
   // Cycles in ST_CAL since the last calibration start; read only by the checks below.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cal_age_reg <= 13'h0000;
      end else if (cal_start) begin
         cal_age_reg <= 13'h0000;
      end else if (state_reg == ST_CAL) begin
         cal_age_reg <= cal_age_reg + 13'h0001;
      end
   end
   //==============================================================
   // Checks.
   a_soft_reset_mode: assert property (@(posedge CLK) disable iff (!ARST_N)
      soft_rst |=> mode_reg == RST_MODE && chan_reg == RST_CHAN) else $error("serial reset missed");
   a_ones_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
      sclk_rise && !din_s[2] |=> ones_reg == 6'h00) else $error("ones count kept");
   a_supply_route: assert property (@(posedge CLK) disable iff (!ARST_N)
      chan_reg == CHAN_SUPPLY && state_reg != ST_CAL |-> INPUT_SEL == IN_SUPPLY && REF_INTERNAL)
      else $error("supply monitor routing wrong");
   a_ref_select: assert property (@(posedge CLK) disable iff (!ARST_N)
      reference_source_select_reg |-> REF_INTERNAL) else $error("reference select ignored");
   a_cal_pin_high: assert property (@(posedge CLK) disable iff (!ARST_N)
      cal_start && !soft_rst |=> DOUT_RDY_N_O throughout (state_reg == ST_CAL)[*1])
      else $error("pin not high");
   a_cal_end_idle: assert property (@(posedge CLK) disable iff (!ARST_N)
      cal_done && !soft_rst |=> state_reg == ST_IDLE && mode_reg == MD_IDLE && rdy_reg && !DOUT_RDY_N_O)
      else $error("calibration end wrong");
   a_int_zero_route: assert property (@(posedge CLK) disable iff (!ARST_N)
      state_reg == ST_CAL && mode_reg == MD_INT_ZERO |-> INPUT_SEL == IN_ZERO)
      else $error("internal zero not routed");
   a_cal_len_long: assert property (@(posedge CLK) disable iff (!ARST_N)
      cal_done && mode_reg == MD_INT_FULL && gain_reg != GAIN_ONE |-> cal_age_reg == 13'(CAL_LONG * CONV_CLKS - 1))
      else $error("full-scale length wrong");
   a_cal_len_short: assert property (@(posedge CLK) disable iff (!ARST_N)
      cal_done && (mode_reg != MD_INT_FULL || gain_reg == GAIN_ONE) |-> cal_age_reg == 13'(CAL_SHORT * CONV_CLKS - 1))
      else $error("two cycle length wrong");
   a_fscale_store: assert property (@(posedge CLK) disable iff (!ARST_N)
      cal_done && mode_reg[0] && !soft_rst |=> fscale_mem[$past(chan_reg)] == $past(RAW_IN))
      else $error("coefficient lost");
   a_soft_reset_coef: assert property (@(posedge CLK) disable iff (!ARST_N)
      soft_rst |=> offset_mem[0] == RST_OFFSET && fscale_mem[7] == RST_FSCALE) else $error("coefficients kept");
   c_cal_done: cover property (@(posedge CLK) disable iff (!ARST_N) cal_done);
   c_soft_reset: cover property (@(posedge CLK) disable iff (!ARST_N) soft_rst);
   c_conv_result: cover property (@(posedge CLK) disable iff (!ARST_N) state_reg == ST_CONV && conv_tick);
   c_cal_long: cover property (@(posedge CLK) disable iff (!ARST_N) cal_done && cal_len == CAL_LONG);
   c_serial_zero: cover property (@(posedge CLK) disable iff (!ARST_N)
      sclk_rise && !din_s[2] && ones_reg != 6'h00);
endmodule : arc_ctrl

// ### inc/arc_pkg.sv
// Package of constants for the converter reset and calibration control block.
//==============================================================
// Notes on behaviour
// - Config bit picks embedded or external reference.
// - Thirty-two serial ones reset all state.
// - Power-up performs the same full reset.
// - Channel code all ones converts supply/6.
// - Mode field offers four calibration modes.
// - Result is (raw minus offset) times full-scale.
// - Calibration end: coefficient, ready, pin low, idle.
// - Internal calibration connects internal zero/full input.
// - Offset calibrations take two conversion cycles.
// - Internal full-scale: 2 cycles gain 1, else 4.
// - Pin high at calibration start, low at end.
// - Full-scale coefficient stored for selected channel.
// - System full-scale takes 2 cycles, always accepted.
package arc_pkg;
   //==============================================================
   // Register word offsets.
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_MODE = 4'h1;
   localparam logic [3:0] OFS_CONFIG = 4'h2;
   localparam logic [3:0] OFS_DATA = 4'h3;
   localparam logic [3:0] OFS_OFFSET = 4'h4;
   localparam logic [3:0] OFS_FSCALE = 4'h5;
   //==============================================================
   // Field positions.
   localparam int POS_MODE = 0;
   localparam int POS_CHAN = 0;
   localparam int POS_GAIN = 8;
   localparam int POS_REFERENCE_SOURCE_SELECT = 7;
   //==============================================================
   // Reset values.
   localparam logic [2:0] RST_MODE = 3'h2;
   localparam logic [2:0] RST_CHAN = 3'h0;
   localparam logic [2:0] RST_GAIN = 3'h7;
   localparam logic RST_REFERENCE_SOURCE_SELECT = 1'b0;
   localparam logic [23:0] RST_OFFSET = 24'h800000;
   localparam logic [23:0] RST_FSCALE = 24'h800000;
   //==============================================================
   // Operating mode codes.
   localparam logic [2:0] MD_CONT = 3'h0;
   localparam logic [2:0] MD_SINGLE = 3'h1;
   localparam logic [2:0] MD_IDLE = 3'h2;
   localparam logic [2:0] MD_PDOWN = 3'h3;
   localparam logic [2:0] MD_INT_ZERO = 3'h4;
   localparam logic [2:0] MD_INT_FULL = 3'h5;
   localparam logic [2:0] MD_SYS_ZERO = 3'h6;
   localparam logic [2:0] MD_SYS_FULL = 3'h7;
   localparam logic [2:0] CHAN_SUPPLY = 3'h7;
   localparam logic [2:0] GAIN_ONE = 3'h0;
   //==============================================================
   // Input routing codes.
   localparam logic [1:0] IN_EXT = 2'h0;
   localparam logic [1:0] IN_ZERO = 2'h1;
   localparam logic [1:0] IN_FULL = 2'h2;
   localparam logic [1:0] IN_SUPPLY = 2'h3;
   //==============================================================
   // Counts.
   localparam int RST_ONES = 32;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CONV_PERIOD_NS = 50000;
   localparam int CONV_CLKS = CONV_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [2:0] CAL_SHORT = 3'h2;
   localparam logic [2:0] CAL_LONG = 3'h4;
   // Calibration sequencer states.
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CAL} arc_state_t;
endpackage : arc_pkg

// ### bench/arc_host_model.sv
// Behavioural serial host that drives the three-wire link pins of the control block.
`timescale 1ns/1ps
module arc_host_model (
   // Serial pins driven towards the device.
   output logic SCLK,
   output logic DIN,
   output logic CS_N
);
   //==============================================================
   // Idle levels: clock parked high, chip deselected.
   initial begin
      SCLK = 1'b1;
      DIN = 1'b1;
      CS_N = 1'b1;
   end
   // Sets the chip-select level that the following frames use.
   task automatic select(input logic sel_n);
      #10;
      CS_N = sel_n;
      #150;
   endtask : select
   // Clocks n copies of one bit at a 400 ns period; data moves while SCLK is low.
   task automatic frame(input int n, input logic val);
      for (int i = 0; i < n; i++) begin
         SCLK = 1'b0;
         DIN = val;
         #200;
         SCLK = 1'b1;
         #200;
      end
      // A released line must not keep showing the last bit.
      DIN = ~val;
      #150;
   endtask : frame
endmodule : arc_host_model

// ### bench/testbench.sv
// Self-checking testbench for the reset and calibration control block.
`timescale 1ns/1ps
module testbench;
   import arc_pkg::*;
   //==============================================================
   // Stimulus and observation signals.
   logic clk;
   logic arst_n;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic sclk, din, cs_n, dout_o, dout_oe, ref_int, soft_rst;
   logic [1:0] in_sel;
   logic [2:0] chan_out;
   logic [23:0] raw_in;
   logic [31:0] rd;
   int error_cnt = 0;
   int checks_done = 0;
   int pulses = 0;
   int cyc = 0;
   int t;
   // Calibration table: mode code, gain code, expected length, expected input routing.
   logic [2:0] cm [5] = '{MD_INT_ZERO, MD_INT_FULL, MD_INT_FULL, MD_SYS_ZERO, MD_SYS_FULL};
   logic [2:0] cg [5] = '{3'h0, 3'h0, 3'h1, 3'h5, 3'h7};
   int ce [5] = '{2000, 2000, 4000, 2000, 2000};
   logic [1:0] cs [5] = '{IN_ZERO, IN_FULL, IN_FULL, IN_EXT, IN_EXT};
   //==============================================================
   // Design and serial host.
   arc_ctrl uut (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .SCLK(sclk), .DIN(din), .CS_N(cs_n), .DOUT_RDY_N_O(dout_o),
      .DOUT_RDY_N_OE(dout_oe), .RAW_IN(raw_in), .REF_INTERNAL(ref_int), .INPUT_SEL(in_sel),
      .CHAN_OUT(chan_out), .SOFT_RESET(soft_rst));
   arc_host_model u_host (.SCLK(sclk), .DIN(din), .CS_N(cs_n));
   //==============================================================
   // Clock at 20 MHz, reset, soft-reset pulse counter and hang guard.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (soft_rst === 1'b1) pulses <= pulses + 1;
      if (cyc == 60000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   // Prints the verdict once and ends the run.
   task automatic report_and_stop();
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // Compares a value against its expectation with four-state equality.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Compares a measured cycle count against a window around its expectation.
   task automatic chk_len(input int got, input int exp);
      checks_done++;
      if (got < exp - 8 || got > exp + 8) begin
         error_cnt++;
         $display("[ERR] %0t length %0d expected %0d", $time, got, exp);
      end
   endtask : chk_len
   // One Avalon-MM cycle: request held until waitrequest is sampled low.
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   // Waits for the ready pin to fall and returns the cycles taken.
   task automatic wait_low();
      t = 0;
      while (dout_o !== 1'b0 && t < 6000) begin
         @(posedge clk);
         t++;
      end
   endtask : wait_low
   //==============================================================
   // Main sequence.
   initial begin
      arst_n = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      raw_in = 24'h0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      // Defaults after power-up, unmapped and read-only places.
      bus(OFS_MODE, 1'b0, 32'h0); chk(rd, 32'h00000002);
      bus(OFS_CONFIG, 1'b0, 32'h0); chk(rd, 32'h00000700);
      bus(OFS_FSCALE, 1'b0, 32'h0); chk(rd, 32'h00800000);
      bus(OFS_STATUS, 1'b1, 32'hFFFFFFFF);
      bus(OFS_STATUS, 1'b0, 32'h0); chk(rd, 32'h00000001);
      bus(4'hF, 1'b1, 32'hFFFFFFFF);
      bus(4'hF, 1'b0, 32'h0); chk(rd, 32'h00000000);
      chk({31'h0, dout_o}, 32'h1);
      // Reference select, then the supply monitor channel.
      bus(OFS_CONFIG, 1'b1, 32'h00000080);
      @(posedge clk); chk({31'h0, ref_int}, 32'h1);
      bus(OFS_CONFIG, 1'b1, 32'h00000007);
      @(posedge clk); chk({29'h0, in_sel, ref_int}, 32'h7);
      chk({29'h0, chan_out}, 32'h7);
      // Every calibration mode on channel 1, with chip select low.
      u_host.select(1'b0);
      for (int i = 0; i < 5; i++) begin
         bus(OFS_CONFIG, 1'b1, {21'h0, cg[i], 8'h01});
         raw_in <= 24'h123450 + 24'(i);
         bus(OFS_MODE, 1'b1, {29'h0, cm[i]});
         repeat (3) @(posedge clk);
         chk({30'h0, dout_oe, dout_o}, 32'h3);
         chk({30'h0, in_sel}, {30'h0, cs[i]});
         wait_low();
         chk_len(t + 3, ce[i]);
         bus(OFS_MODE, 1'b0, 32'h0); chk(rd, 32'h00000002);
         bus(OFS_STATUS, 1'b0, 32'h0); chk(rd, 32'h00000000);
         bus((i == 0 || i == 3) ? OFS_OFFSET : OFS_FSCALE, 1'b0, 32'h0);
         chk(rd, {8'h0, 24'h123450 + 24'(i)});
      end
      // Full-scale coefficient belongs to the channel that was selected.
      bus(OFS_CONFIG, 1'b1, 32'h00000002);
      bus(OFS_FSCALE, 1'b0, 32'h0); chk(rd, 32'h00800000);
      // Scaled conversion on channel 0: (0x1100 - 0x100) * 0x400000 >> 23.
      bus(OFS_CONFIG, 1'b1, 32'h00000000);
      bus(OFS_OFFSET, 1'b1, 32'h00000100);
      bus(OFS_FSCALE, 1'b1, 32'h00400000);
      raw_in <= 24'h001100;
      // Reading the data register drops the ready left over from the last calibration.
      bus(OFS_DATA, 1'b0, 32'h0);
      chk(rd, 32'h00000000);
      bus(OFS_MODE, 1'b1, {29'h0, MD_SINGLE});
      wait_low();
      bus(OFS_DATA, 1'b0, 32'h0); chk(rd, 32'h00000800);
      bus(OFS_STATUS, 1'b0, 32'h0); chk(rd[0], 1'b1);
      // Serial reset: ignored when deselected, broken by a zero, then 32 ones.
      bus(OFS_CONFIG, 1'b1, 32'h00000082);
      u_host.select(1'b1);
      u_host.frame(32, 1'b1);
      chk(pulses, 32'h0);
      chk({31'h0, dout_oe}, 32'h0);
      u_host.select(1'b0);
      u_host.frame(31, 1'b1);
      u_host.frame(1, 1'b0);
      u_host.frame(31, 1'b1);
      chk(pulses, 32'h0);
      u_host.frame(1, 1'b1);
      repeat (10) @(posedge clk);
      chk(pulses, 32'h1);
      // The host keeps off the registers for 500 us after a reset.
      repeat (10000) @(posedge clk);
      bus(OFS_CONFIG, 1'b0, 32'h0); chk(rd, 32'h00000700);
      bus(OFS_OFFSET, 1'b0, 32'h0); chk(rd, 32'h00800000);
      chk({31'h0, ref_int}, 32'h0);
      report_and_stop();
   end
endmodule : testbench
